// ==== design/dcpwm_pkg.sv ====
/*
 * Constants for the two-channel pulse width modulator: register offsets,
 * field positions, widths and reset values.
 * Assumes a 32-bit APB slave port with byte addresses on paddr.
 */
package dcpwm_pkg;

	// ==========================================================
	// Widths
	localparam int DCPWM_ADDR_W = 8;                // APB address bits decoded
	localparam int DCPWM_CNT_W = 16;                // Period, duty and phase width
	localparam int DCPWM_PRE_W = 8;                 // Width of each prescale stage
	localparam int DCPWM_NCH = 2;                   // Number of output channels

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] DCPWM_OFF_CTRL = 8'h00;      // Enables and edge modes
	localparam logic [7:0] DCPWM_OFF_PRESCALE = 8'h04;  // Both prescale stages
	localparam logic [7:0] DCPWM_OFF_CH0_LIMIT = 8'h08; // Channel 0 period limit
	localparam logic [7:0] DCPWM_OFF_CH0_DUTY = 8'h0C;  // Channel 0 duty match
	localparam logic [7:0] DCPWM_OFF_CH0_PHASE = 8'h10; // Channel 0 phase
	localparam logic [7:0] DCPWM_OFF_CH1_LIMIT = 8'h14; // Channel 1 period limit
	localparam logic [7:0] DCPWM_OFF_CH1_DUTY = 8'h18;  // Channel 1 duty match
	localparam logic [7:0] DCPWM_OFF_CH1_PHASE = 8'h1C; // Channel 1 phase
	localparam logic [7:0] DCPWM_OFF_STATUS = 8'h20;    // Live period counters

	// ==========================================================
	// Field positions
	localparam int DCPWM_CTRL_EN_LSB = 0;           // Output enable, one bit per channel
	localparam int DCPWM_CTRL_DUAL_LSB = 2;         // Dual-edge select, one bit per channel
	localparam int DCPWM_PRE_A_LSB = 0;             // Stage a in PRESCALE
	localparam int DCPWM_PRE_B_LSB = 8;             // Stage b in PRESCALE

	// ==========================================================
	// Reset values
	localparam logic [3:0] DCPWM_RST_CTRL = 4'h0;
	localparam logic [7:0] DCPWM_RST_PRE = 8'h00;
	localparam logic [15:0] DCPWM_RST_LIMIT = 16'h00FF;
	localparam logic [15:0] DCPWM_RST_DUTY = 16'h0000;
	localparam logic [15:0] DCPWM_RST_PHASE = 16'h0000;

endpackage

// ==== design/dcpwm_top.sv ====
/*
 * Two-channel pulse width modulator with an APB register slave.
 * Both channels share a two-stage prescaler; each has its own period limit,
 * duty match, phase, edge mode and output enable.
 * Assumes one 100 MHz clock and an APB master that holds a request until
 * it samples pready high.
 */

module dcpwm_top
	import dcpwm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [DCPWM_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Modulated outputs
	output logic [DCPWM_NCH-1:0] pwm_out
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [3:0] ctrl;                       // Enables and edge modes
		logic [DCPWM_PRE_W-1:0] prescale_stage_a; // First divider setting
		logic [DCPWM_PRE_W-1:0] prescale_stage_b; // Second divider setting
		logic [DCPWM_NCH-1:0][DCPWM_CNT_W-1:0] channel_period_limit;
		logic [DCPWM_NCH-1:0][DCPWM_CNT_W-1:0] channel_duty_match;
		logic [DCPWM_NCH-1:0][DCPWM_CNT_W-1:0] channel_phase;
		logic [DCPWM_PRE_W-1:0] div_a;          // First stage counter
		logic [DCPWM_PRE_W-1:0] div_b;          // Second stage counter
		logic [DCPWM_NCH-1:0][DCPWM_CNT_W-1:0] period_cnt; // Per channel period counters
		logic [DCPWM_NCH-1:0] out;              // Registered outputs
		logic ready;                            // APB answer
		logic slverr;                           // Unmapped address answer
		logic [31:0] rdata;                     // APB read data
	} dcpwm_state_t;

	dcpwm_state_t state_reg;
	dcpwm_state_t state_next;
	logic tick_a;                               // First stage wraps this cycle
	logic tick;                                 // Shared prescaled tick
	logic hit;                                  // Address maps to a register
	logic [31:0] cur_val;                       // Current value at the address
	logic [31:0] wr_val;                        // Value after byte-lane merge

	// ==========================================================
	// Functions

	// Byte-lane merge of write data over old contents
	function automatic logic [31:0] dcpwm_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return res;
	endfunction

	// Waveform level for one channel at one counter value
	function automatic logic dcpwm_wave(input logic [15:0] cnt, input logic [15:0] limit,
		input logic [15:0] duty, input logic [15:0] phase, input logic dual);
		logic [16:0] span;
		logic [16:0] pos;
		logic [16:0] lo;
		span = {1'b0, limit} + 17'h00001;
		// Phase moves the start of the waveform; out-of-range phase acts as zero
		if (phase > limit) begin
			pos = {1'b0, cnt};
		end else if (cnt >= phase) begin
			pos = {1'b0, cnt} - {1'b0, phase};
		end else begin
			pos = {1'b0, cnt} + span - {1'b0, phase};
		end
		lo = (span - {1'b0, duty}) >> 1;
		if (duty > limit) begin
			return 1'b1;
		end else if (!dual) begin
			return pos < {1'b0, duty};
		end else begin
			// Pulse centred in the period
			return (pos >= lo) && (pos < lo + {1'b0, duty});
		end
	endfunction

	// ==========================================================
	// Next state
	always_comb begin
		state_next = state_reg;
		// Cascaded prescaler; >= keeps it sane if a stage shrinks mid-count
		tick_a = state_reg.div_a >= state_reg.prescale_stage_a;
		tick = tick_a && (state_reg.div_b >= state_reg.prescale_stage_b);
		if (tick_a) begin
			state_next.div_a = '0;
			state_next.div_b = (state_reg.div_b >= state_reg.prescale_stage_b) ? '0 :
				state_reg.div_b + 8'h01;
		end else begin
			state_next.div_a = state_reg.div_a + 8'h01;
		end
		// Channels run side by side on the shared tick
		for (int ch = 0; ch < DCPWM_NCH; ch++) begin
			if (tick) begin
				if (state_reg.period_cnt[ch] >= state_reg.channel_period_limit[ch]) begin
					state_next.period_cnt[ch] = '0;
				end else begin
					state_next.period_cnt[ch] = state_reg.period_cnt[ch] + 16'h0001;
				end
			end
			// Disabled channel drives a steady low
			state_next.out[ch] = state_reg.ctrl[DCPWM_CTRL_EN_LSB + ch] &&
				dcpwm_wave(state_reg.period_cnt[ch], state_reg.channel_period_limit[ch],
				state_reg.channel_duty_match[ch], state_reg.channel_phase[ch],
				state_reg.ctrl[DCPWM_CTRL_DUAL_LSB + ch]);
		end
		// Address decode and current contents
		hit = 1'b1;
		unique case ({paddr[7:2], 2'b00})
			DCPWM_OFF_CTRL: cur_val = {28'h0000000, state_reg.ctrl};
			DCPWM_OFF_PRESCALE: cur_val = {16'h0000, state_reg.prescale_stage_b, state_reg.prescale_stage_a};
			DCPWM_OFF_CH0_LIMIT: cur_val = {16'h0000, state_reg.channel_period_limit[0]};
			DCPWM_OFF_CH0_DUTY: cur_val = {16'h0000, state_reg.channel_duty_match[0]};
			DCPWM_OFF_CH0_PHASE: cur_val = {16'h0000, state_reg.channel_phase[0]};
			DCPWM_OFF_CH1_LIMIT: cur_val = {16'h0000, state_reg.channel_period_limit[1]};
			DCPWM_OFF_CH1_DUTY: cur_val = {16'h0000, state_reg.channel_duty_match[1]};
			DCPWM_OFF_CH1_PHASE: cur_val = {16'h0000, state_reg.channel_phase[1]};
			DCPWM_OFF_STATUS: cur_val = {state_reg.period_cnt[1], state_reg.period_cnt[0]};
			default: begin
				cur_val = 32'h00000000;
				hit = 1'b0;
			end
		endcase
		wr_val = dcpwm_merge(cur_val, pwdata, pstrb);
		// APB: one wait state, then pready for one cycle
		state_next.ready = 1'b0;
		state_next.slverr = 1'b0;
		if (psel && penable && !state_reg.ready) begin
			state_next.ready = 1'b1;
			state_next.slverr = !hit;
			state_next.rdata = pwrite ? 32'h00000000 : cur_val;
		end
		// Write lands at the edge where the master samples pready
		if (psel && penable && state_reg.ready && pwrite && hit) begin
			unique case ({paddr[7:2], 2'b00})
				DCPWM_OFF_CTRL: state_next.ctrl = wr_val[3:0];
				DCPWM_OFF_PRESCALE: begin
					state_next.prescale_stage_a = wr_val[DCPWM_PRE_A_LSB +: DCPWM_PRE_W];
					state_next.prescale_stage_b = wr_val[DCPWM_PRE_B_LSB +: DCPWM_PRE_W];
				end
				DCPWM_OFF_CH0_LIMIT: state_next.channel_period_limit[0] = wr_val[15:0];
				DCPWM_OFF_CH0_DUTY: state_next.channel_duty_match[0] = wr_val[15:0];
				DCPWM_OFF_CH0_PHASE: state_next.channel_phase[0] = wr_val[15:0];
				DCPWM_OFF_CH1_LIMIT: state_next.channel_period_limit[1] = wr_val[15:0];
				DCPWM_OFF_CH1_DUTY: state_next.channel_duty_match[1] = wr_val[15:0];
				DCPWM_OFF_CH1_PHASE: state_next.channel_phase[1] = wr_val[15:0];
				default: begin
					// Status is read-only
				end
			endcase
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg.ctrl <= DCPWM_RST_CTRL;
			state_reg.prescale_stage_a <= DCPWM_RST_PRE;
			state_reg.prescale_stage_b <= DCPWM_RST_PRE;
			state_reg.channel_period_limit <= {DCPWM_NCH{DCPWM_RST_LIMIT}};
			state_reg.channel_duty_match <= {DCPWM_NCH{DCPWM_RST_DUTY}};
			state_reg.channel_phase <= {DCPWM_NCH{DCPWM_RST_PHASE}};
			state_reg.div_a <= '0;
			state_reg.div_b <= '0;
			state_reg.period_cnt <= '0;
			state_reg.out <= '0;
			state_reg.ready <= 1'b0;
			state_reg.slverr <= 1'b0;
			state_reg.rdata <= 32'h00000000;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from flip-flops
	assign prdata = state_reg.rdata;
	assign pready = state_reg.ready;
	assign pslverr = state_reg.slverr;
	assign pwm_out = state_reg.out;

	// ==========================================================
	// Assertions
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_apb_access;
		psel && penable && !pready;
	endsequence
	sequence s_answer_pulse;
		pready ##1 !pready;
	endsequence

	property p_apb_answer;
		s_apb_access |=> s_answer_pulse;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("pready not a one-cycle answer");

	property p_disabled_low;
		!state_reg.ctrl[DCPWM_CTRL_EN_LSB] |=> !pwm_out[0];
	endproperty
	a_disabled_low: assert property (p_disabled_low) else $error("disabled channel not low");

	property p_wrap;
		tick && state_reg.period_cnt[0] == state_reg.channel_period_limit[0]
			|=> state_reg.period_cnt[0] == 16'h0000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter failed to wrap at limit");

	property p_hold_between_ticks;
		!tick |=> $stable(state_reg.period_cnt);
	endproperty
	a_hold_between_ticks: assert property (p_hold_between_ticks) else $error("counter moved without tick");

	// Both stages restart together after a tick
	property p_tick_cause;
		tick |=> state_reg.div_a == 8'h00 && state_reg.div_b == 8'h00;
	endproperty
	a_tick_cause: assert property (p_tick_cause) else $error("stages not restarted after tick");

	property p_full_duty;
		state_reg.ctrl[DCPWM_CTRL_EN_LSB + 1] &&
			state_reg.channel_duty_match[1] > state_reg.channel_period_limit[1] |=> pwm_out[1];
	endproperty
	a_full_duty: assert property (p_full_duty) else $error("duty above limit not high");

	property p_single_edge;
		state_reg.ctrl[DCPWM_CTRL_EN_LSB] && !state_reg.ctrl[DCPWM_CTRL_DUAL_LSB] &&
			state_reg.channel_phase[0] == 16'h0000 &&
			state_reg.channel_duty_match[0] <= state_reg.channel_period_limit[0]
			|=> pwm_out[0] == ($past(state_reg.period_cnt[0]) < $past(state_reg.channel_duty_match[0]));
	endproperty
	a_single_edge: assert property (p_single_edge) else $error("single-edge level wrong");

	property p_dual_zero;
		state_reg.ctrl[DCPWM_CTRL_DUAL_LSB + 1] && state_reg.channel_duty_match[1] == 16'h0000 |=> !pwm_out[1];
	endproperty
	a_dual_zero: assert property (p_dual_zero) else $error("dual-edge zero duty not low");

	property p_phase_start;
		state_reg.ctrl[DCPWM_CTRL_EN_LSB] && !state_reg.ctrl[DCPWM_CTRL_DUAL_LSB] &&
			state_reg.channel_duty_match[0] != 16'h0000 &&
			state_reg.channel_phase[0] <= state_reg.channel_period_limit[0] &&
			state_reg.period_cnt[0] == state_reg.channel_phase[0] |=> pwm_out[0];
	endproperty
	a_phase_start: assert property (p_phase_start) else $error("output not high at phase point");

	// ==========================================================
	// Prescaler, channel 1 and bus checks

	// First stage counts up between its wraps
	property p_stage_a_step;
		!tick_a |=> state_reg.div_a == $past(state_reg.div_a) + 8'h01;
	endproperty
	a_stage_a_step: assert property (p_stage_a_step) else $error("first stage did not count");

	// Second stage steps once per first-stage wrap
	property p_stage_b_step;
		tick_a && !tick |=> state_reg.div_b == $past(state_reg.div_b) + 8'h01;
	endproperty
	a_stage_b_step: assert property (p_stage_b_step) else $error("second stage did not step");

	// Channel 1 disabled drives low
	property p_disabled_low_ch1;
		!state_reg.ctrl[DCPWM_CTRL_EN_LSB + 1] |=> !pwm_out[1];
	endproperty
	a_disabled_low_ch1: assert property (p_disabled_low_ch1) else $error("disabled ch1 not low");

	// Channel 1 counter wraps at its own limit
	property p_wrap_ch1;
		tick && state_reg.period_cnt[1] == state_reg.channel_period_limit[1]
			|=> state_reg.period_cnt[1] == 16'h0000;
	endproperty
	a_wrap_ch1: assert property (p_wrap_ch1) else $error("ch1 counter failed to wrap at limit");

	// Channel 1 single-edge level follows its counter
	property p_single_edge_ch1;
		state_reg.ctrl[DCPWM_CTRL_EN_LSB + 1] && !state_reg.ctrl[DCPWM_CTRL_DUAL_LSB + 1] &&
			state_reg.channel_phase[1] == 16'h0000 &&
			state_reg.channel_duty_match[1] <= state_reg.channel_period_limit[1]
			|=> pwm_out[1] == ($past(state_reg.period_cnt[1]) < $past(state_reg.channel_duty_match[1]));
	endproperty
	a_single_edge_ch1: assert property (p_single_edge_ch1) else $error("ch1 single-edge level wrong");

	// Channel 1 rises at its phase point
	property p_phase_start_ch1;
		state_reg.ctrl[DCPWM_CTRL_EN_LSB + 1] && !state_reg.ctrl[DCPWM_CTRL_DUAL_LSB + 1] &&
			state_reg.channel_duty_match[1] != 16'h0000 &&
			state_reg.channel_phase[1] <= state_reg.channel_period_limit[1] &&
			state_reg.period_cnt[1] == state_reg.channel_phase[1] |=> pwm_out[1];
	endproperty
	a_phase_start_ch1: assert property (p_phase_start_ch1) else $error("ch1 not high at phase point");

	// Unmapped addresses answer with an error, mapped ones without
	property p_apb_error;
		s_apb_access |=> pslverr == !$past(hit);
	endproperty
	a_apb_error: assert property (p_apb_error) else $error("pslverr does not match decode");

	// An error only comes with the answer and carries zero data
	property p_error_with_ready;
		pslverr |-> pready && prdata == 32'h00000000;
	endproperty
	a_error_with_ready: assert property (p_error_with_ready) else $error("pslverr outside answer");

	// Writes return zero read data
	property p_write_data_zero;
		pready && pwrite |-> prdata == 32'h00000000;
	endproperty
	a_write_data_zero: assert property (p_write_data_zero) else $error("write answer carries data");

	// No answer without a select
	property p_ready_idle;
		!psel |=> !pready;
	endproperty
	a_ready_idle: assert property (p_ready_idle) else $error("pready without psel");

	// A full-word write to the channel 0 limit lands at the answer edge
	property p_limit_write;
		psel && penable && pready && pwrite && pstrb == 4'hF && paddr == DCPWM_OFF_CH0_LIMIT
			|=> {16'h0000, state_reg.channel_period_limit[0]} == ($past(pwdata) & 32'h0000FFFF);
	endproperty
	a_limit_write: assert property (p_limit_write) else $error("limit write did not land");

endmodule

// ==== testbench/dcpwm_load_model.sv ====
/*
 * Load-side model for the two modulated outputs: counts high cycles and
 * rising edges of each channel, and flags each rising edge.
 * Assumes the outputs are registered levels sampled on the rising clock edge.
 */
module dcpwm_load_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Window clear from the bench
	input wire logic clr,
	// Drive lines from the modulator
	input wire logic [1:0] pwm_in,
	// Measurements
	output logic [1:0] rise,
	output logic [1:0][31:0] hi_cnt,
	output logic [1:0][31:0] rise_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] prev_reg; // Level seen at the previous edge

	// A rising edge is a high level after a low one
	assign rise = pwm_in & ~prev_reg;

	// ==========================================================
	// Counters, cleared for each measuring window
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_reg <= '0;
			hi_cnt <= '0;
			rise_cnt <= '0;
		end else begin
			prev_reg <= pwm_in;
			for (int i = 0; i < 2; i++) begin
				hi_cnt[i] <= clr ? 32'h0 : hi_cnt[i] + {31'h0, pwm_in[i]};
				rise_cnt[i] <= clr ? 32'h0 : rise_cnt[i] + {31'h0, rise[i]};
			end
		end
	end
endmodule

// ==== testbench/dual_channel_pwm_test.sv ====
/*
 * Self-checking bench for the two-channel modulator: APB master tasks,
 * reset values, duty and frequency windows, phase and dual-edge offsets.
 * Assumes the APB slave answers with pready and the load model above.
 */
module dual_channel_pwm_test;
	import dcpwm_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr;
	logic [1:0] pwm_out, rise;
	logic [1:0][31:0] hi_cnt, rise_cnt;
	int num_errors = 0, samples_checked = 0;

	always #5 clk = ~clk; // 100 MHz

	dcpwm_top u_dcpwm_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pwm_out(pwm_out));
	dcpwm_load_model u_dcpwm_load_model (.clk(clk), .rst_n(rst_n), .clr(clr), .pwm_in(pwm_out),
		.rise(rise), .hi_cnt(hi_cnt), .rise_cnt(rise_cnt));

	// ==========================================================
	// Verdict and comparison
	task automatic end_sim();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// ==========================================================
	// APB master: holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			chk(32'h1, 32'h0, "no pready");
			end_sim();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic e;
		apb(1'b1, a, d, 4'hF, rd, e);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		logic e;
		apb(1'b0, a, 32'h0, 4'hF, rd, e);
		chk(rd, exp, "read data");
		chk({31'h0, e}, 32'h0, "read error");
	endtask

	// Count high cycles and rises over n edges
	task automatic window(input int n);
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Cycles from a channel 1 rise to the next channel 0 rise
	task automatic meas(output int off);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rise[1] !== 1'b1 && n < 64);
		off = 0;
		while (rise[0] !== 1'b1 && off < 64) begin
			@(posedge clk);
			off++;
		end
		if (n >= 64 || off >= 64) begin
			chk(32'h1, 32'h0, "no rising edge");
			end_sim();
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		logic [7:0] offs[8] = '{DCPWM_OFF_CTRL, DCPWM_OFF_PRESCALE, DCPWM_OFF_CH0_LIMIT, DCPWM_OFF_CH0_DUTY,
			DCPWM_OFF_CH0_PHASE, DCPWM_OFF_CH1_LIMIT, DCPWM_OFF_CH1_DUTY, DCPWM_OFF_CH1_PHASE};
		logic [31:0] exps[8] = '{32'h0, 32'h0, 32'h00FF, 32'h0, 32'h0, 32'h00FF, 32'h0, 32'h0};
		logic [31:0] rd;
		logic e;
		chk({30'h0, pwm_out}, 32'h0, "idle output");
		foreach (offs[i]) rd_chk(offs[i], exps[i]);
		apb(1'b0, 8'h24, 32'h0, 4'hF, rd, e);
		chk({31'h0, e}, 32'h1, "unmapped error");
		chk(rd, 32'h0, "unmapped data");
		apb(1'b1, DCPWM_OFF_PRESCALE, 32'h0000_0302, 4'h2, rd, e);
		rd_chk(DCPWM_OFF_PRESCALE, 32'h0000_0300);
	endtask

	task automatic t_duty();
		wr(DCPWM_OFF_PRESCALE, 32'h0000_0201);
		wr(DCPWM_OFF_CH0_LIMIT, 32'h3);
		wr(DCPWM_OFF_CH0_DUTY, 32'h2);
		wr(DCPWM_OFF_CH1_LIMIT, 32'h4);
		wr(DCPWM_OFF_CH1_DUTY, 32'h5);
		wr(DCPWM_OFF_CTRL, 32'h3);
		repeat (40) @(posedge clk);
		window(120);
		chk(rise_cnt[0], 32'd5, "ch0 periods");
		chk(hi_cnt[0], 32'd60, "ch0 high");
		chk(rise_cnt[1], 32'd0, "ch1 periods");
		chk(hi_cnt[1], 32'd120, "ch1 high");
		wr(DCPWM_OFF_CH0_DUTY, 32'h0);
		wr(DCPWM_OFF_CTRL, 32'h1);
		repeat (40) @(posedge clk);
		window(120);
		chk(hi_cnt[0], 32'd0, "ch0 zero duty");
		chk(hi_cnt[1], 32'd0, "ch1 disabled");
	endtask

	task automatic t_phase();
		int o0, o1, o2;
		wr(DCPWM_OFF_PRESCALE, 32'h0);
		wr(DCPWM_OFF_CH0_LIMIT, 32'h7);
		wr(DCPWM_OFF_CH0_DUTY, 32'h4);
		wr(DCPWM_OFF_CH1_LIMIT, 32'h7);
		wr(DCPWM_OFF_CH1_DUTY, 32'h4);
		wr(DCPWM_OFF_CTRL, 32'h3);
		repeat (40) @(posedge clk);
		meas(o0);
		wr(DCPWM_OFF_CH0_PHASE, 32'h3);
		repeat (20) @(posedge clk);
		meas(o1);
		chk(32'((o1 - o0 + 8) % 8), 32'd3, "phase shift");
		wr(DCPWM_OFF_CH0_PHASE, 32'h0);
		wr(DCPWM_OFF_CTRL, 32'h7);
		repeat (20) @(posedge clk);
		meas(o2);
		chk(32'((o2 - o0 + 8) % 8), 32'd2, "dual edge start");
		wr(DCPWM_OFF_CH1_DUTY, 32'h0);
		wr(DCPWM_OFF_CTRL, 32'hF);
		repeat (20) @(posedge clk);
		window(120);
		chk(hi_cnt[0], 32'h3C, "ch0 dual duty");
		chk(rise_cnt[0], 32'hF, "ch0 dual periods");
		chk(hi_cnt[1], 32'h0, "ch1 dual zero duty");
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_duty();
		t_phase();
		end_sim();
	end

	initial begin
		#100000;
		num_errors++;
		end_sim();
	end
endmodule
